/* include/otc_pkg.sv */
// Purpose: Shared constants and types for the output step trigger controller.
// Assumes: One clock, AXI4-Lite register access with 32-bit data words.
// Notes:   Channel registers repeat at a stride of 16 bytes above the globals.
// Behaviour
// - An accepted trigger moves voltage and current settings to the triggered levels.
// - Immediate trigger from host or panel fires whatever source is selected.
// - Bus source accepts device trigger, trigger command or group execute trigger.
// - Every channel starts idle after power-up.
// - Idle channels discard all triggers and change no setting.
// - Initiate moves each listed channel from idle to initiated.
// - Initiated channel waits for a trigger from its selected source.
// - After the triggered action the channel returns to idle.
// - Pin or channel source waits forever, no timeout.
// - Abort forces an initiated channel back to idle.
// - Step mode loads triggered level; fixed mode keeps immediate level.
// - Channel with neither function in step mode makes no output change.
// - Enabled trigger out pulses when the step occurs, to channels or pins.
package otc_pkg;
  localparam int NCH           = 4;
  localparam int NPIN          = 7;
  localparam int LW            = 16;
  localparam int AW            = 8;
  localparam logic [AW-1:0] CMD_OFS  = 8'h00;
  localparam logic [AW-1:0] STAT_OFS = 8'h04;
  localparam logic [AW-1:0] PCFG_OFS = 8'h08;
  localparam logic [AW-1:0] EVT_OFS  = 8'h0C;
  localparam logic [AW-1:0] CH_BASE  = 8'h10;
  localparam logic [AW-1:0] CH_END   = 8'h50;
  localparam logic [3:0]    CH_LVL   = 4'h0;
  localparam logic [3:0]    CH_TRG   = 4'h4;
  localparam logic [3:0]    CH_CFG   = 4'h8;
  localparam logic [3:0]    CH_STA   = 4'hC;
  localparam int CMD_INIT_LSB  = 0;
  localparam int CMD_ABORT_LSB = 4;
  localparam int CMD_TRIG_LSB  = 8;
  localparam int CMD_BUS_BIT   = 12;
  localparam int PCFG_OUT_LSB  = 8;
  localparam int LVL_I_LSB     = 16;
  localparam logic [31:0] LVL_RST  = 32'h0000_0000;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] PCFG_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_BUS  = 2'h0,
    SRC_PIN  = 2'h1,
    SRC_TRAN = 2'h2
  } otc_src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_STEP = 2'b11
  } otc_state_e;

  typedef struct packed {
    logic       trig_out_en;
    logic       istep;
    logic       vstep;
    logic [2:0] idx;
    logic [1:0] kind;
  } otc_cfg_s;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } otc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } otc_axi_rsp_s;
endpackage : otc_pkg

/* design/otc_chan.sv */
// Purpose: Per-channel idle/initiated trigger sequencer.
// Assumes: All trigger inputs are one-cycle pulses on aclk.
// Notes:   Outputs are registered; a step lasts one cycle.
`timescale 1ns/100ps
module otc_chan
  import otc_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            initiate,
  input  wire logic            abort,
  input  wire logic            imm_trig,
  input  wire logic            bus_trig,
  input  wire logic [NPIN-1:0] pin_edge,
  input  wire logic [NCH-1:0]  tran_in,
  input  wire otc_cfg_s        cfg,
  output logic                 initiated,
  output logic                 step_v,
  output logic                 step_i,
  output logic                 trig_out
);
  typedef struct packed {
    otc_state_e st;
    logic       step_v;
    logic       step_i;
    logic       pulse;
  } otc_chan_s;

  otc_chan_s q;
  otc_chan_s d;
  logic      src_hit;
  logic      fire;

  always_comb begin
    case (otc_src_e'(cfg.kind))
      SRC_BUS:  src_hit = bus_trig;
      SRC_PIN:  src_hit = (int'(cfg.idx) < NPIN) ? pin_edge[cfg.idx] : 1'b0;
      SRC_TRAN: src_hit = (int'(cfg.idx) < NCH) ? tran_in[cfg.idx[1:0]] : 1'b0;
      default:  src_hit = 1'b0;
    endcase
    fire = imm_trig | src_hit;
  end

  always_comb begin
    d        = q;
    d.step_v = 1'b0;
    d.step_i = 1'b0;
    d.pulse  = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (initiate) begin
          d.st = ST_INIT;
        end
      end
      ST_INIT: begin
        if (abort) begin
          d.st = ST_IDLE;
        end else if (fire) begin
          d.st = ST_STEP;
        end
      end
      ST_STEP: begin
        d.st     = ST_IDLE;
        d.step_v = cfg.vstep;
        d.step_i = cfg.istep;
        d.pulse  = cfg.trig_out_en & (cfg.vstep | cfg.istep);
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign initiated = (q.st != ST_IDLE);
  assign step_v    = q.step_v;
  assign step_i    = q.step_i;
  assign trig_out  = q.pulse;
endmodule : otc_chan

/* design/otc_top.sv */
// Purpose: Output step trigger controller with AXI4-Lite registers.
// Assumes: Digital port pins are asynchronous; panel and GET pulses are on aclk.
// Notes:   A hardware step wins over a software write to the same level.
`timescale 1ns/100ps
module otc_top
  import otc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire otc_axi_req_s           s_axi_req,
  output otc_axi_rsp_s                s_axi_rsp,
  input  wire logic [NCH-1:0]         panel_trig,
  input  wire logic                   bus_get_trig,
  input  wire logic [NPIN-1:0]        port_pin_in,
  output logic [NPIN-1:0]             port_trigger_output,
  output logic [NCH-1:0]              chan_trig_out,
  output logic [NCH-1:0][LW-1:0]      out_voltage,
  output logic [NCH-1:0][LW-1:0]      out_current
);
  typedef struct packed {
    logic                  have_aw;
    logic [AW-1:0]         awaddr;
    logic                  have_w;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [NCH-1:0][31:0]  lvl;
    logic [NCH-1:0][31:0]  trg;
    logic [NCH-1:0][7:0]   cfg;
    logic [15:0]           pcfg;
    logic [NCH-1:0]        evt;
    logic [NCH-1:0]        init_p;
    logic [NCH-1:0]        abort_p;
    logic [NCH-1:0]        itrig_p;
    logic                  bus_p;
    logic [NPIN-1:0]       s1;
    logic [NPIN-1:0]       s2;
    logic [NPIN-1:0]       s3;
    logic [NPIN-1:0]       pto;
  } otc_top_s;

  otc_top_s         q;
  otc_top_s         d;
  logic [NCH-1:0]   initiated;
  logic [NCH-1:0]   step_v;
  logic [NCH-1:0]   step_i;
  logic [NCH-1:0]   chan_pulse;
  logic [NPIN-1:0]  pin_edge;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic in_ch(input logic [AW-1:0] a);
    return (a >= CH_BASE) && (a < CH_END);
  endfunction : in_ch

  function automatic logic [1:0] ch_of(input logic [AW-1:0] a);
    logic [AW-1:0] rel;
    rel = a - CH_BASE;
    return rel[5:4];
  endfunction : ch_of

  function automatic logic [AW-1:0] glob_ofs(input logic [AW-1:0] a);
    return {a[AW-1:2], 2'b00};
  endfunction : glob_ofs

  function automatic logic [3:0] chan_ofs(input logic [AW-1:0] a);
    return a[3:0] & 4'hC;
  endfunction : chan_ofs

  assign pin_edge = q.s2 & ~q.s3 & q.pcfg[NPIN-1:0];

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    otc_chan u_chan (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .initiate  (q.init_p[c]),
      .abort     (q.abort_p[c]),
      .imm_trig  (q.itrig_p[c] | panel_trig[c]),
      .bus_trig  (q.bus_p | bus_get_trig),
      .pin_edge  (pin_edge),
      .tran_in   (chan_pulse),
      .cfg       (otc_cfg_s'(q.cfg[c])),
      .initiated (initiated[c]),
      .step_v    (step_v[c]),
      .step_i    (step_i[c]),
      .trig_out  (chan_pulse[c])
    );
  end

  always_comb begin
    logic [31:0] cmdw;
    logic [31:0] merged;
    logic [1:0]  wc;
    logic [1:0]  rc;
    logic [NCH-1:0] clr;
    cmdw   = '0;
    merged = '0;
    wc     = ch_of(q.awaddr);
    rc     = ch_of(s_axi_req.araddr);
    clr    = '0;
    d         = q;
    d.init_p  = '0;
    d.abort_p = '0;
    d.itrig_p = '0;
    d.bus_p   = 1'b0;
    d.s1      = port_pin_in;
    d.s2      = q.s1;
    d.s3      = q.s2;
    d.pto     = q.pcfg[PCFG_OUT_LSB +: NPIN] & {NPIN{|chan_pulse}};

    if (s_axi_req.awvalid && !q.have_aw) begin
      d.have_aw = 1'b1;
      d.awaddr  = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && !q.have_w) begin
      d.have_w = 1'b1;
      d.wdata  = s_axi_req.wdata;
      d.wstrb  = s_axi_req.wstrb;
    end
    if (q.bvalid && s_axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (q.have_aw && q.have_w && !q.bvalid) begin
      d.have_aw = 1'b0;
      d.have_w  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (in_ch(q.awaddr)) begin
        case (chan_ofs(q.awaddr))
          CH_LVL: begin
            d.lvl[wc] = wmerge(q.lvl[wc], q.wdata, q.wstrb);
          end
          CH_TRG: begin
            d.trg[wc] = wmerge(q.trg[wc], q.wdata, q.wstrb);
          end
          CH_CFG: begin
            merged    = wmerge({24'h00_0000, q.cfg[wc]}, q.wdata, q.wstrb);
            d.cfg[wc] = merged[7:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (glob_ofs(q.awaddr))
          CMD_OFS: begin
            cmdw      = wmerge(32'h0000_0000, q.wdata, q.wstrb);
            d.init_p  = cmdw[CMD_INIT_LSB +: NCH];
            d.abort_p = cmdw[CMD_ABORT_LSB +: NCH];
            d.itrig_p = cmdw[CMD_TRIG_LSB +: NCH];
            d.bus_p   = cmdw[CMD_BUS_BIT];
          end
          STAT_OFS: begin
          end
          PCFG_OFS: begin
            merged = wmerge({16'h0000, q.pcfg}, q.wdata, q.wstrb);
            d.pcfg = merged[15:0];
          end
          EVT_OFS: begin
            merged = wmerge(32'h0000_0000, q.wdata, q.wstrb);
            clr    = merged[NCH-1:0];
          end
          default: begin
            d.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    if (q.rvalid && s_axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      if (in_ch(s_axi_req.araddr)) begin
        case (chan_ofs(s_axi_req.araddr))
          CH_LVL:  d.rdata = q.lvl[rc];
          CH_TRG:  d.rdata = q.trg[rc];
          CH_CFG:  d.rdata = {24'h00_0000, q.cfg[rc]};
          CH_STA:  d.rdata = {30'h0000_0000, q.evt[rc], initiated[rc]};
          default: d.rdata = '0;
        endcase
      end else begin
        case (glob_ofs(s_axi_req.araddr))
          CMD_OFS:  d.rdata = '0;
          STAT_OFS: d.rdata = {28'h000_0000, initiated};
          PCFG_OFS: d.rdata = {16'h0000, q.pcfg};
          EVT_OFS:  d.rdata = {28'h000_0000, q.evt};
          default: begin
            d.rresp = RESP_SLVERR;
          end
        endcase
      end
    end

    d.evt = q.evt & ~clr;
    for (int c = 0; c < NCH; c++) begin
      if (step_v[c]) begin
        d.lvl[c][LW-1:0] = q.trg[c][LW-1:0];
      end
      if (step_i[c]) begin
        d.lvl[c][LVL_I_LSB +: LW] = q.trg[c][LVL_I_LSB +: LW];
      end
      if (step_v[c] | step_i[c]) begin
        d.evt[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.lvl  <= {NCH{LVL_RST}};
      q.trg  <= {NCH{LVL_RST}};
      q.cfg  <= {NCH{CFG_RST}};
      q.pcfg <= PCFG_RST;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    s_axi_rsp         = '0;
    s_axi_rsp.awready = !q.have_aw;
    s_axi_rsp.wready  = !q.have_w;
    s_axi_rsp.bvalid  = q.bvalid;
    s_axi_rsp.bresp   = q.bresp;
    s_axi_rsp.arready = !q.rvalid;
    s_axi_rsp.rvalid  = q.rvalid;
    s_axi_rsp.rdata   = q.rdata;
    s_axi_rsp.rresp   = q.rresp;
  end

  assign port_trigger_output = q.pto;
  assign chan_trig_out       = chan_pulse;
  for (genvar c = 0; c < NCH; c++) begin : g_out
    assign out_voltage[c] = q.lvl[c][LW-1:0];
    assign out_current[c] = q.lvl[c][LVL_I_LSB +: LW];
  end
endmodule : otc_top

/* test/otc_top_monitor.sv */
// Purpose: Port checker for the output step trigger controller.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every otc_top instance.
`timescale 1ns/100ps
module otc_top_monitor
  import otc_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire otc_axi_req_s           s_axi_req,
  input wire otc_axi_rsp_s           s_axi_rsp,
  input wire logic [NCH-1:0]         panel_trig,
  input wire logic                   bus_get_trig,
  input wire logic [NPIN-1:0]        port_pin_in,
  input wire logic [NPIN-1:0]        port_trigger_output,
  input wire logic [NCH-1:0]         chan_trig_out,
  input wire logic [NCH-1:0][LW-1:0] out_voltage,
  input wire logic [NCH-1:0][LW-1:0] out_current
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [NPIN-1:0] pin_q;
  logic [3:0]      quiet_q;
  logic            cause;
  // Counts clocks since anything that may legally move a level.
  assign cause = s_axi_req.wvalid | s_axi_rsp.bvalid | (|panel_trig) | bus_get_trig
               | (|chan_trig_out) | (port_pin_in != pin_q);
  always_ff @(posedge aclk) begin
    pin_q <= port_pin_in;
    if (!aresetn || cause) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence aw_w_taken;
    s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready
      && !s_axi_rsp.bvalid;
  endsequence
  sequence ar_taken;
    s_axi_req.arvalid && s_axi_rsp.arready;
  endsequence
  chk_reset_zero:
    assert property ($rose(aresetn) |-> out_voltage == '0 && out_current == '0
      && chan_trig_out == '0) else $error("outputs not cleared by reset");
  chk_level_cause:
    assert property (($changed(out_voltage) || $changed(out_current)) |-> quiet_q < 4'hC)
      else $error("level moved without a cause");
  chk_pin_out_cause:
    assert property (|port_trigger_output |-> $past(chan_trig_out) != '0)
      else $error("port trigger without channel trigger");
  chk_trig_pulse:
    assert property (|chan_trig_out |=> (chan_trig_out & $past(chan_trig_out)) == '0)
      else $error("trigger out longer than one clock");
  chk_write_answer:
    assert property (aw_w_taken |-> ##2 s_axi_rsp.bvalid) else $error("write answer late");
  chk_read_answer:
    assert property (ar_taken |=> s_axi_rsp.rvalid) else $error("read answer late");
  chk_aw_block:
    assert property (s_axi_req.awvalid && s_axi_rsp.awready |=> !s_axi_rsp.awready)
      else $error("address accepted twice");
  chk_ar_block:
    assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
      else $error("read accepted while answer pending");
endmodule : otc_top_monitor
bind otc_top otc_top_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
  .panel_trig(panel_trig), .bus_get_trig(bus_get_trig), .port_pin_in(port_pin_in),
  .port_trigger_output(port_trigger_output), .chan_trig_out(chan_trig_out),
  .out_voltage(out_voltage), .out_current(out_current));

/* test/otc_port_model.sv */
// Purpose: Digital port partner driving one input pin and counting output pulses.
// Assumes: Pins idle low; the pin changes off the clock phase.
// Notes:   The pin is held four clocks so the synchroniser always catches it.
`timescale 1ns/100ps
module otc_port_model
  import otc_pkg::*;
#(
  parameter int IN_PIN  = 2,
  parameter int OUT_PIN = 5
)
(
  input wire logic            aclk,
  input wire logic            fire,
  input wire logic [NPIN-1:0] pto,
  output logic [NPIN-1:0]     pins,
  output int                  pulses
);
  int hold = 0;
  initial pins = '0;
  initial pulses = 0;
  always @(posedge aclk) begin
    if (fire) hold = 4;
    else if (hold > 0) hold = hold - 1;
    pins <= #37 (hold > 0) ? (NPIN'(1) << IN_PIN) : '0;
    if (pto[OUT_PIN] === 1'b1) pulses = pulses + 1;
  end
endmodule : otc_port_model

/* test/output_step_trigger_control_test.sv */
// Purpose: Self-checking bench for the output step trigger controller.
// Assumes: Register map and timing as handed over with the design.
// Notes:   Ordinary trigger cases run from a table; abort and chaining follow.
`timescale 1ns/100ps
module output_step_trigger_control_test
  import otc_pkg::*;
;
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] cfg;
    logic [2:0] kind;
    logic       ev;
    logic       ei;
  } otc_row_s;
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  otc_axi_req_s           req = '0;
  otc_axi_rsp_s           rsp;
  logic [NCH-1:0]         panel = '0;
  logic                   bus_trg = 1'b0;
  logic                   fire = 1'b0;
  logic [NPIN-1:0]        pins;
  logic [NPIN-1:0]        pto;
  logic [NCH-1:0]         cto;
  logic [NCH-1:0][LW-1:0] ov;
  logic [NCH-1:0][LW-1:0] oc;
  logic [31:0]            rdat;
  logic [31:0]            lvl;
  logic [31:0]            trg;
  logic [1:0]             resp;
  logic [LW-1:0]          v2;
  int                     pulses;
  int                     p0;
  int                     err_total = 0;
  int                     checked = 0;
  // Kinds: 0 immediate, 1 bus command, 2 group trigger, 3 panel, 4 pin.
  otc_row_s rows [7] = '{'{2'd0, 8'h60, 3'd0, 1'b1, 1'b1}, '{2'd1, 8'h61, 3'd0, 1'b1, 1'b1},
                         '{2'd2, 8'h60, 3'd1, 1'b1, 1'b1}, '{2'd3, 8'h60, 3'd2, 1'b1, 1'b1},
                         '{2'd0, 8'h20, 3'd3, 1'b1, 1'b0}, '{2'd1, 8'h00, 3'd0, 1'b0, 1'b0},
                         '{2'd2, 8'h69, 3'd4, 1'b1, 1'b1}};
  always #50 aclk = ~aclk;
  otc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .panel_trig(panel), .bus_get_trig(bus_trg), .port_pin_in(pins),
    .port_trigger_output(pto), .chan_trig_out(cto), .out_voltage(ov), .out_current(oc));
  otc_port_model pm (.aclk(aclk), .fire(fire), .pto(pto), .pins(pins), .pulses(pulses));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk_word
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk_resp
  task automatic hang;
    $display("BAD wait expected answer seen none");
    err_total++;
    give_verdict();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (int n = 0; n < 40 && !fin; n++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        req.bready <= 1'b0;
        resp = rsp.bresp;
        fin = 1'b1;
      end
    end
    if (!fin) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 40 && !fin; n++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        req.rready <= 1'b0;
        rdat = rsp.rdata;
        resp = rsp.rresp;
        fin = 1'b1;
      end
    end
    if (!fin) hang();
  endtask : rd
  task automatic wait_idle(input logic [3:0] m);
    for (int n = 0; n < 20; n++) begin
      rd(STAT_OFS);
      if ((rdat[3:0] & m) === 4'h0) return;
    end
    hang();
  endtask : wait_idle
  task automatic fire_kind(input int k, input int c);
    if (k < 2) begin
      wr(CMD_OFS, 32'h1 << ((k == 0) ? CMD_TRIG_LSB + c : CMD_BUS_BIT));
    end else begin
      if (k == 4) begin
        repeat (30) @(posedge aclk);
        rd(STAT_OFS);
        chk_word("still waiting", 32'h1 << c, rdat & (32'h1 << c));
      end
      @(posedge aclk);
      bus_trg <= (k == 2);
      panel <= (k == 3) ? NCH'(1) << c : '0;
      fire <= (k == 4);
      @(posedge aclk);
      bus_trg <= 1'b0;
      panel <= '0;
      fire <= 1'b0;
    end
  endtask : fire_kind
  function automatic logic [7:0] chan_adr(input int c, input logic [3:0] o);
    return CH_BASE + 8'(c * 16) + {4'h0, o};
  endfunction : chan_adr
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int c = 0; c < NCH; c++) chk_word("levels at reset", '0, {ov[c], oc[c]});
    rd(STAT_OFS);
    chk_word("status at reset", '0, rdat);
    chk_resp("read response", RESP_OKAY, resp);
    rd(8'h50);
    chk_resp("unmapped read", RESP_SLVERR, resp);
    wr(8'h50, 32'h0000_0000);
    chk_resp("unmapped write", RESP_SLVERR, resp);
    wr(PCFG_OFS, 32'h0000_2004);
    chk_resp("write response", RESP_OKAY, resp);
    foreach (rows[r]) begin
      lvl = {8'h10, 8'(r), 8'h20, 8'(r)};
      trg = {8'h30, 8'(r), 8'h40, 8'(r)};
      wr(chan_adr(rows[r].ch, CH_LVL), lvl);
      wr(chan_adr(rows[r].ch, CH_TRG), trg);
      wr(chan_adr(rows[r].ch, CH_CFG), {24'h0, rows[r].cfg});
      wr(CMD_OFS, 32'h1 << (CMD_INIT_LSB + rows[r].ch));
      rd(STAT_OFS);
      chk_word("initiated", 32'h1 << rows[r].ch, rdat & 32'hF);
      fire_kind(rows[r].kind, rows[r].ch);
      wait_idle(4'h1 << rows[r].ch);
      chk_word("voltage", rows[r].ev ? trg[15:0] : lvl[15:0], ov[rows[r].ch]);
      chk_word("current", rows[r].ei ? trg[31:16] : lvl[31:16], oc[rows[r].ch]);
    end
    // Channel 2 is initiated then aborted; channel 0 is left idle after its step.
    v2 = ov[2];
    wr(chan_adr(0, CH_TRG), 32'h7777_8888);
    wr(CMD_OFS, 32'h1 << (CMD_INIT_LSB + 2));
    wr(CMD_OFS, 32'h1 << (CMD_ABORT_LSB + 2));
    rd(STAT_OFS);
    chk_word("aborted", '0, rdat);
    wr(CMD_OFS, 32'h5 << CMD_TRIG_LSB);
    rd(STAT_OFS);
    chk_word("idle discard", {16'h0, v2}, {16'h0, ov[2]});
    chk_word("no reinitiate", 32'h3000_4004, {16'h3000, ov[0]});
    // Channel 1 steps on channel 0's trigger out, which also reaches pin 5.
    wr(chan_adr(0, CH_CFG), 32'h0000_00A0);
    wr(chan_adr(1, CH_CFG), 32'h0000_0022);
    wr(chan_adr(1, CH_TRG), 32'h0000_0ABC);
    p0 = pulses;
    wr(CMD_OFS, 32'h3 << CMD_INIT_LSB);
    fire_kind(0, 0);
    wait_idle(4'h3);
    chk_word("source voltage", 32'h8888, {16'h0, ov[0]});
    chk_word("chained voltage", 32'h0ABC, {16'h0, ov[1]});
    chk_word("pin pulses", 32'(p0 + 1), 32'(pulses));
    rd(EVT_OFS);
    chk_word("step events", 32'h0000_000F, rdat);
    wr(EVT_OFS, 32'h0000_0005);
    rd(chan_adr(0, CH_STA));
    chk_word("event cleared", 32'h0000_0000, rdat);
    rd(chan_adr(1, CH_STA));
    chk_word("event kept", 32'h0000_0002, rdat);
    give_verdict();
  end
endmodule : output_step_trigger_control_test
